// ### verilog/tad_core.sv
// The plain strobed port and the register addresses were chosen for this implementation.
`timescale 1ns/1ps
`include "tad_cfg.svh"
module tad_core #(
  parameter int POINTS = `TAD_POINTS
) (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic [7:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata,
  input wire tad_pkg::tad_sample_type smp_in,
  output logic busy,
  output logic stat_done
);
  import tad_pkg::*;

  // ****************************************
  // Registers
  // ****************************************
  logic [31:0] ctrl;
  logic [17:0] trace_mode;
  logic [23:0] trace_det;
  logic [11:0] filt;
  logic [14:0] ptr;
  logic [5:0] fresh;
  logic cont_single;
  logic meas_start;
  logic [15:0] sweeps_done;
  logic [15:0] mem [0:`TAD_NUM_TRACES*512-1];
  logic [15:0] rd_word;
  tad_det_set_type det_cur, det_prev;
  logic [15:0] ap_max, ap_min;
  tad_state_type state;
  logic fin_sweep;
  logic first_pt;

  wire [14:0] sweep_count = ctrl[14:0];
  wire continuous = ctrl[`TAD_CTRL_CONT_BIT];
  wire [1:0] rep_shift = ctrl[`TAD_CTRL_REP_LSB +: 2];
  wire [3:0] avg_shift = ctrl[`TAD_CTRL_AVG_LSB +: 4];
  wire wr_mode = reg_wr && reg_addr == `TAD_ADDR_MODE;

  function automatic tad_mode_type mode_of(input logic [17:0] m, input logic [2:0] t);
    mode_of = tad_mode_type'(m[t*3 +: 3]);
  endfunction

  function automatic logic [15:0] det_pick(input tad_det_set_type d, input logic [3:0] sel);
    unique case (tad_det_type'(sel))
      auto_peak_tag, positive_peak_tag: det_pick = d.pos;
      negative_peak_tag: det_pick = d.neg;
      random_sample_tag: det_pick = d.smp;
      root_mean_square_tag: det_pick = d.rms;
      linear_average_tag: det_pick = d.avg;
      quasi_peak_tag: det_pick = d.qp;
      standard_rms_tag: det_pick = d.crms;
      standard_average_tag: det_pick = d.cavg;
      default: det_pick = d.pos;
    endcase
  endfunction

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      ctrl <= `TAD_CTRL_RST;
      trace_mode <= `TAD_MODE_RST;
      trace_det <= `TAD_DET_RST;
      filt <= `TAD_FILT_RST;
      ptr <= 15'h0000;
    end else if (reg_wr) begin
      unique case (reg_addr)
        `TAD_ADDR_CTRL: ctrl <= reg_wdata;
        `TAD_ADDR_MODE: trace_mode <= reg_wdata[17:0];
        `TAD_ADDR_DET: trace_det <= reg_wdata[23:0];
        `TAD_ADDR_FILT: filt <= reg_wdata[11:0];
        `TAD_ADDR_PTR: ptr <= reg_wdata[14:0];
        default: ;
      endcase
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      meas_start <= 1'b0;
    end else begin
      meas_start <= reg_wr && reg_addr == `TAD_ADDR_CMD && reg_wdata[`TAD_CMD_START_BIT];
    end
  end

  // Mode change wins over the end-of-sweep clear, so a new mode never inherits
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      fresh <= 6'h3F;
    end else begin
      for (int t = 0; t < `TAD_NUM_TRACES; t++) begin
        if (wr_mode && reg_wdata[t*3 +: 3] != trace_mode[t*3 +: 3]) begin
          fresh[t] <= 1'b1;
        end else if (fin_sweep || meas_start) begin
          fresh[t] <= meas_start;
        end
      end
    end
  end

  // Fresh traces read as cleared memory
  always_ff @(posedge clk_sys) begin
    rd_word <= fresh[ptr[`TAD_PTR_TRACE_LSB +: 3]] ? 16'h0000 :
               mem[{ptr[`TAD_PTR_TRACE_LSB +: 3], ptr[8:0]}];
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      reg_rdata <= 32'h0000_0000;
    end else if (reg_rd) begin
      unique case (reg_addr)
        `TAD_ADDR_CTRL: reg_rdata <= ctrl;
        `TAD_ADDR_MODE: reg_rdata <= {14'h0000, trace_mode};
        `TAD_ADDR_DET: reg_rdata <= {8'h00, trace_det};
        `TAD_ADDR_FILT: reg_rdata <= {20'h00000, filt};
        `TAD_ADDR_PTR: reg_rdata <= {17'h00000, ptr};
        `TAD_ADDR_DATA: reg_rdata <= {16'h0000, rd_word};
        `TAD_ADDR_STAT: reg_rdata <= {13'h0000, cont_single, busy, stat_done, sweeps_done};
        `TAD_ADDR_APK: reg_rdata <= {ap_min, ap_max};
        default: reg_rdata <= 32'h0000_0000;
      endcase
    end else begin
      reg_rdata <= 32'h0000_0000;
    end
  end

  // ****************************************
  // Detectors, crms and cavg stepping at point ends, the rest on every sample outside S_HALT
  // ****************************************
  logic [15:0] mx, mn, sp, qp, crms, cavg;
  logic [31:0] sum;
  logic [47:0] sumsq;
  logic first;
  logic [15:0] lfsr;
  wire [15:0] x = smp_in.value;
  wire tick = smp_in.valid && state != S_HALT;
  wire pt_end = tick && smp_in.point_end;
  wire [15:0] mx_i = (first || x > mx) ? x : mx;
  wire [15:0] mn_i = (first || x < mn) ? x : mn;
  wire [15:0] sp_i = (first || lfsr[3:0] == 4'h0) ? x : sp;
  wire [31:0] sum_i = (first ? 32'h0 : sum) + {16'h0000, x};
  wire [47:0] sq_i = (first ? 48'h0 : sumsq) + {16'h0000, 32'(x) * 32'(x)};
  wire [31:0] avg_w = sum_i >> avg_shift;
  wire [47:0] ms_w = sq_i >> avg_shift;
  wire [15:0] rms_i = ms_w[31:16];
  wire [16:0] cr_d = {1'b0, rms_i} - {1'b0, crms};
  wire [16:0] ca_d = {1'b0, avg_w[15:0]} - {1'b0, cavg};
  wire [16:0] qp_d = {1'b0, x} - {1'b0, qp};
  // Filter outputs include the point just ended, so the trace never lags a point
  wire [15:0] qp_i = qp_d[16] ? qp - (qp >> filt[7:4]) : qp + (qp_d[15:0] >> filt[3:0]);
  wire [15:0] cr_i = crms + 16'(signed'(cr_d) >>> filt[11:8]);
  wire [15:0] ca_i = cavg + 16'(signed'(ca_d) >>> filt[11:8]);

  // One flop set feeds every detector so trace choice never slows the sweep
  always_ff @(posedge clk_sys) begin
    if (rst || meas_start) begin
      first <= 1'b1;
      {mx, mn, sp, sum, sumsq} <= '0;
      {qp, crms, cavg} <= '0;
      lfsr <= 16'hACE1;
    end else if (tick) begin
      lfsr <= {lfsr[14:0], lfsr[15] ^ lfsr[13] ^ lfsr[12] ^ lfsr[10]};
      first <= smp_in.point_end;
      mx <= mx_i;
      mn <= mn_i;
      sp <= sp_i;
      sum <= sum_i;
      sumsq <= sq_i;
      qp <= qp_i;
      if (smp_in.point_end) begin
        crms <= cr_i;
        cavg <= ca_i;
      end
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst || meas_start) begin
      det_cur <= '0;
      det_prev <= '0;
      ap_max <= 16'h0000;
      ap_min <= 16'h0000;
    end else if (pt_end && state == S_IDLE) begin
      det_prev <= first_pt ? tad_det_set_type'({mx_i, mn_i, sp_i, rms_i, avg_w[15:0],
                                                 qp_i, cr_i, ca_i}) : det_cur;
      det_cur <= {mx_i, mn_i, sp_i, rms_i, avg_w[15:0], qp_i, cr_i, ca_i};
      ap_max <= mx_i;
      ap_min <= mn_i;
    end
  end

  // ****************************************
  // Trace update sequencer
  // ****************************************
  logic sweep_pend;
  logic [8:0] pidx;
  logic [2:0] tr;
  logic [3:0] rep_j;
  logic [4:0] div_cnt;
  logic [16:0] rem;
  logic [15:0] quot;
  logic neg_d;
  logic [15:0] old_v;
  logic [15:0] weight;

  wire [15:0] n_cur = sweeps_done + 16'h0001;
  wire [3:0] rep_n = 4'h1 << rep_shift;
  wire tad_mode_type tm = mode_of(trace_mode, tr);
  wire [15:0] v_cur = det_pick(det_cur, trace_det[tr*4 +: 4]);
  wire [15:0] v_prev = det_pick(det_prev, trace_det[tr*4 +: 4]);
  wire signed [17:0] v_diff = $signed({2'b00, v_cur}) - $signed({2'b00, v_prev});
  wire signed [22:0] v_scl = v_diff * $signed({1'b0, rep_j});
  wire [15:0] tv = 16'(v_prev + 16'(v_scl >>> rep_shift));
  wire [11:0] widx = {tr, pidx};
  wire [15:0] mem_old = mem[widx];
  wire [16:0] a_diff = {1'b0, tv} - {1'b0, mem_old};
  wire [16:0] rem_sh = {rem[15:0], quot[15]};
  wire last_step = tr == 3'h5 && rep_j == rep_n;
  wire stop_single = !continuous && sweep_count != 15'h0 && !cont_single &&
                     sweeps_done >= {1'b0, sweep_count};

  always_comb begin
    if (sweep_count == 15'h0) begin
      weight = `TAD_ZERO_WEIGHT;
    end else if (sweep_count == 15'h1) begin
      weight = 16'h0001;
    end else if (n_cur <= {1'b0, sweep_count}) begin
      weight = n_cur;
    end else begin
      weight = {1'b0, sweep_count};
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst || meas_start) begin
      state <= S_IDLE;
      busy <= 1'b0;
      tr <= 3'h0;
      rep_j <= 4'h1;
      div_cnt <= 5'h00;
      rem <= 17'h00000;
      quot <= 16'h0000;
      neg_d <= 1'b0;
      old_v <= 16'h0000;
      pidx <= 9'h000;
      first_pt <= 1'b1;
      sweep_pend <= 1'b0;
    end else begin
      unique case (state)
        S_IDLE: begin
          if (stop_single) begin
            state <= S_HALT;
          end else if (pt_end) begin
            state <= S_STEP;
            busy <= 1'b1;
            sweep_pend <= smp_in.sweep_end;
            tr <= 3'h0;
            rep_j <= 4'h1;
          end
        end
        S_HALT: begin
          if (!stop_single) begin
            state <= S_IDLE;
          end
        end
        S_STEP: begin
          if (tm == TM_AVERAGE && !fresh[tr] && weight != 16'h0001) begin
            state <= S_DIV;
            neg_d <= a_diff[16];
            quot <= a_diff[16] ? 16'(-a_diff) : a_diff[15:0];
            rem <= 17'h00000;
            old_v <= mem_old;
            div_cnt <= `TAD_DIV_STEPS;
          end else begin
            if (last_step) begin
              state <= S_IDLE;
              busy <= 1'b0;
            end
            tr <= tr == 3'h5 ? 3'h0 : tr + 3'h1;
            rep_j <= tr == 3'h5 ? rep_j + 4'h1 : rep_j;
            pidx <= !(tr == 3'h5) ? pidx : (last_step && sweep_pend) ? 9'h000 :
                    (pidx == 9'(POINTS - 1)) ? pidx : pidx + 9'h001;
            first_pt <= last_step && sweep_pend;
          end
        end
        S_DIV: begin
          div_cnt <= div_cnt - 5'h01;
          if (rem_sh >= {1'b0, weight}) begin
            rem <= rem_sh - {1'b0, weight};
            quot <= {quot[14:0], 1'b1};
          end else begin
            rem <= rem_sh;
            quot <= {quot[14:0], 1'b0};
          end
          if (div_cnt == 5'h01) begin
            state <= S_STEP;
          end
        end
        default: state <= S_IDLE;
      endcase
      if (state == S_DIV && div_cnt == 5'h01) begin
        // Write-back happens below; advance here as in the direct path
        if (last_step) begin
          state <= S_IDLE;
          busy <= 1'b0;
        end
        tr <= tr == 3'h5 ? 3'h0 : tr + 3'h1;
        rep_j <= tr == 3'h5 ? rep_j + 4'h1 : rep_j;
        pidx <= !(tr == 3'h5) ? pidx : (last_step && sweep_pend) ? 9'h000 :
                (pidx == 9'(POINTS - 1)) ? pidx : pidx + 9'h001;
        first_pt <= last_step && sweep_pend;
      end
    end
  end

  wire div_done = state == S_DIV && div_cnt == 5'h01;
  wire [15:0] q_fin = rem_sh >= {1'b0, weight} ? {quot[14:0], 1'b1} : {quot[14:0], 1'b0};
  wire [15:0] avg_new = neg_d ? old_v - q_fin : old_v + q_fin;
  wire step_dir = state == S_STEP && !(tm == TM_AVERAGE && !fresh[tr] &&
                                         weight != 16'h0001);
  assign fin_sweep = (step_dir || div_done) && last_step && sweep_pend;

  // Trace memory holds only linear values, so averaging never sees log units
  always_ff @(posedge clk_sys) begin
    if (div_done) begin
      mem[widx] <= avg_new;
    end else if (step_dir) begin
      unique case (tm)
        TM_CLEAR_WRITE, TM_AVERAGE: mem[widx] <= tv;
        TM_MAX_HOLD: if (fresh[tr] || tv > mem_old) mem[widx] <= tv;
        TM_MIN_HOLD: if (fresh[tr] || tv < mem_old) mem[widx] <= tv;
        default: ;
      endcase
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst || meas_start) begin
      sweeps_done <= 16'h0000;
      stat_done <= 1'b0;
      cont_single <= 1'b0;
    end else begin
      if (reg_wr && reg_addr == `TAD_ADDR_CMD && reg_wdata[`TAD_CMD_CONT_BIT]) begin
        cont_single <= 1'b1;
      end
      if (fin_sweep) begin
        sweeps_done <= sweeps_done == 16'hFFFF ? sweeps_done : n_cur;
        if (n_cur == {1'b0, sweep_count}) begin
          stat_done <= 1'b1;
        end
      end
    end
  end

  // ****************************************
  // Checks
  // ****************************************
  sequence s_start;
    meas_start;
  endsequence
  sequence s_finish;
    fin_sweep && n_cur == {1'b0, sweep_count};
  endsequence

  property p_index_reset;
    @(posedge clk_sys) disable iff (rst) s_start |=> sweeps_done == 16'h0000;
  endproperty
  a_index_reset: assert property (p_index_reset) else $error("index not cleared");

  property p_index_step;
    @(posedge clk_sys) disable iff (rst || meas_start)
      fin_sweep && sweeps_done != 16'hFFFF |=> sweeps_done == $past(sweeps_done) + 16'h0001;
  endproperty
  a_index_step: assert property (p_index_step) else $error("index not advanced");

  property p_cycle_done;
    @(posedge clk_sys) disable iff (rst || meas_start)
      s_finish |=> stat_done;
  endproperty
  a_cycle_done: assert property (p_cycle_done) else $error("cycle not flagged");

  property p_run_weight;
    @(posedge clk_sys) disable iff (rst)
      sweep_count > 15'h1 && n_cur <= {1'b0, sweep_count} |-> weight == n_cur;
  endproperty
  a_run_weight: assert property (p_run_weight) else $error("running weight wrong");

  property p_cont_weight;
    @(posedge clk_sys) disable iff (rst)
      sweep_count > 15'h1 && n_cur > {1'b0, sweep_count} |-> weight == {1'b0, sweep_count};
  endproperty
  a_cont_weight: assert property (p_cont_weight) else $error("count weight wrong");

  property p_zero_weight;
    @(posedge clk_sys) disable iff (rst) sweep_count == 15'h0 |-> weight == 16'h000A;
  endproperty
  a_zero_weight: assert property (p_zero_weight) else $error("zero count weight");

  property p_one_direct;
    @(posedge clk_sys) disable iff (rst)
      sweep_count == 15'h1 && state == S_STEP |-> step_dir;
  endproperty
  a_one_direct: assert property (p_one_direct) else $error("count one averaged");

  property p_mode_clear;
    @(posedge clk_sys) disable iff (rst)
      wr_mode && reg_wdata[2:0] != trace_mode[2:0] |=> fresh[0];
  endproperty
  a_mode_clear: assert property (p_mode_clear) else $error("mode change kept data");

  property p_reset_modes;
    @(posedge clk_sys) rst |=> trace_mode == 18'h2DB68;
  endproperty
  a_reset_modes: assert property (p_reset_modes) else $error("reset modes wrong");

  property p_peak_order;
    @(posedge clk_sys) disable iff (rst || meas_start)
      pt_end && state == S_IDLE |=> det_cur.pos >= det_cur.neg && ap_max == det_cur.pos;
  endproperty
  a_peak_order: assert property (p_peak_order) else $error("peak below minimum");

  property p_max_hold;
    @(posedge clk_sys) disable iff (rst)
      step_dir && tm == TM_MAX_HOLD && !fresh[tr] && tv <= mem_old |=>
      mem[$past(widx)] == $past(mem_old);
  endproperty
  a_max_hold: assert property (p_max_hold) else $error("max hold lowered");
endmodule

// ### verilog/tad_cfg.svh
`ifndef TAD_CFG_SVH
`define TAD_CFG_SVH
// Register byte addresses
`define TAD_ADDR_CTRL 8'h00
`define TAD_ADDR_MODE 8'h04
`define TAD_ADDR_DET 8'h08
`define TAD_ADDR_CMD 8'h0C
`define TAD_ADDR_FILT 8'h10
`define TAD_ADDR_PTR 8'h14
`define TAD_ADDR_DATA 8'h18
`define TAD_ADDR_STAT 8'h1C
`define TAD_ADDR_APK 8'h20
// Field positions
`define TAD_CTRL_CONT_BIT 15
`define TAD_CTRL_REP_LSB 16
`define TAD_CTRL_AVG_LSB 20
`define TAD_CMD_START_BIT 0
`define TAD_CMD_CONT_BIT 1
`define TAD_PTR_TRACE_LSB 12
// Reset values
`define TAD_CTRL_RST 32'h0000_8000
`define TAD_MODE_RST 18'h2DB68
`define TAD_DET_RST 24'h000000
`define TAD_FILT_RST 12'h444
// Averaging constants, trace count and points per trace
`define TAD_ZERO_WEIGHT 16'h000A
`define TAD_DIV_STEPS 5'h10
`define TAD_NUM_TRACES 6
`define TAD_POINTS 501
`endif

// ### verilog/tad_pkg.sv
package tad_pkg;
  typedef enum logic [2:0] {
    TM_CLEAR_WRITE = 3'h0,
    TM_MAX_HOLD = 3'h1,
    TM_MIN_HOLD = 3'h2,
    TM_AVERAGE = 3'h3,
    TM_VIEW = 3'h4,
    TM_BLANK = 3'h5
  } tad_mode_type;
  typedef enum logic [3:0] {
    auto_peak_tag = 4'h0,
    positive_peak_tag = 4'h1,
    negative_peak_tag = 4'h2,
    random_sample_tag = 4'h3,
    root_mean_square_tag = 4'h4,
    linear_average_tag = 4'h5,
    quasi_peak_tag = 4'h6,
    standard_rms_tag = 4'h7,
    standard_average_tag = 4'h8
  } tad_det_type;
  typedef enum logic [3:0] {
    S_IDLE = 4'h1,
    S_STEP = 4'h2,
    S_DIV = 4'h4,
    S_HALT = 4'h8
  } tad_state_type;
  typedef struct packed {
    logic valid;
    logic [15:0] value;
    logic point_end;
    logic sweep_end;
  } tad_sample_type;
  typedef struct packed {
    logic [15:0] pos;
    logic [15:0] neg;
    logic [15:0] smp;
    logic [15:0] rms;
    logic [15:0] avg;
    logic [15:0] qp;
    logic [15:0] crms;
    logic [15:0] cavg;
  } tad_det_set_type;
endpackage

// ### testbench/tb_trace_averaging_detectors.sv
`timescale 1ns/1ps
`include "tad_cfg.svh"
module tb_trace_averaging_detectors;
  import tad_pkg::*;
  // ********************
  // Signals and clock
  // ********************
  logic clk_sys = 1'b0;
  logic rst = 1'b1;
  logic [7:0] reg_addr = 8'h00;
  logic [31:0] reg_wdata = 32'h0;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [31:0] reg_rdata;
  tad_sample_type smp_in = '0;
  logic busy;
  logic stat_done;
  int fail_count = 0;
  int cmp_count = 0;
  int cycles = 0;
  logic [31:0] rv;
  // Sweep values and expected traces, chosen to divide exactly
  localparam logic [15:0] cur [5] = '{16'h012C, 16'h0064, 16'h00C8, 16'h0190, 16'h028A};
  localparam logic [15:0] avg [5] = '{16'h012C, 16'h00C8, 16'h00C8, 16'h00FA, 16'h015E};
  localparam logic [15:0] mxh [5] = '{16'h012C, 16'h012C, 16'h012C, 16'h0190, 16'h028A};
  localparam logic [15:0] mnh [5] = '{16'h012C, 16'h0064, 16'h0064, 16'h0064, 16'h0064};

  // Four points keep each sweep short
  tad_core #(.POINTS(4)) tad_core_inst (
    .clk_sys(clk_sys),
    .rst(rst),
    .reg_addr(reg_addr),
    .reg_wdata(reg_wdata),
    .reg_wr(reg_wr),
    .reg_rd(reg_rd),
    .reg_rdata(reg_rdata),
    .smp_in(smp_in),
    .busy(busy),
    .stat_done(stat_done)
  );

  initial begin
    forever #25 clk_sys = ~clk_sys;
  end

  always @(posedge clk_sys) begin
    cycles <= cycles + 1;
    if (cycles == 40000) begin
      fail_count++;
      tally_and_finish();
    end
  end

  // ********************
  // Shared tasks
  // ********************
  task automatic tally_and_finish();
    $display("compares %0d mismatches %0d", cmp_count, fail_count);
    if (fail_count == 0 && cmp_count > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    cmp_count++;
    if (got !== exp) begin
      fail_count++;
      $display("wrong value at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask

  // Rounding of the divider is the designer's, so one count either way passes
  task automatic chkn(input logic [31:0] got, input logic [31:0] exp, input string what);
    cmp_count++;
    if (!(got === exp || got === exp + 1 || got + 1 === exp)) begin
      fail_count++;
      $display("wrong value at %0t: %s got %h near %h", $time, what, got, exp);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_sys);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk_sys);
    reg_wr <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a);
    @(posedge clk_sys);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk_sys);
    reg_rd <= 1'b0;
    #1 rv = reg_rdata;
  endtask

  task automatic peek(input logic [2:0] t, input logic [8:0] p);
    wr(`TAD_ADDR_PTR, {17'h0, t, 3'h0, p});
    rd(`TAD_ADDR_DATA);
  endtask

  // Point ends are spaced well past the longest trace update any scenario here triggers
  task automatic smp(input logic [15:0] v, input logic pe, input logic se);
    @(posedge clk_sys);
    smp_in <= '{valid: 1'b1, value: v, point_end: pe, sweep_end: se};
    @(posedge clk_sys);
    smp_in <= '0;
    if (pe) repeat (120) @(posedge clk_sys);
  endtask

  task automatic sweep(input logic [15:0] v);
    for (int p = 0; p < 4; p++) smp(v, 1'b1, p == 3);
  endtask

  task automatic start(input logic [31:0] cmd);
    wr(`TAD_ADDR_CMD, cmd);
    repeat (2) @(posedge clk_sys);
  endtask

  function automatic logic [31:0] mp(input tad_mode_type t0, t1, t2);
    return {14'h0, TM_BLANK, TM_BLANK, TM_BLANK, t2, t1, t0};
  endfunction

  // ********************
  // Scenarios
  // ********************
  task automatic s_reset();
    chk({30'h0, busy, stat_done}, 32'h0, "idle flags");
    rd(`TAD_ADDR_CTRL);
    chk(rv, 32'h0000_8000, "ctrl reset");
    rd(`TAD_ADDR_MODE);
    chk(rv, mp(TM_CLEAR_WRITE, TM_BLANK, TM_BLANK), "mode reset");
    rd(`TAD_ADDR_DET);
    chk(rv, 32'h0, "det reset");
    rd(`TAD_ADDR_FILT);
    chk(rv, 32'h0000_0444, "filt reset");
    rd(8'h24);
    chk(rv, 32'h0, "unmapped");
    wr(`TAD_ADDR_STAT, 32'hFFFF_FFFF);
    rd(`TAD_ADDR_STAT);
    chk(rv, 32'h0, "status read only");
  endtask

  task automatic s_detect();
    wr(`TAD_ADDR_CTRL, 32'h0020_8001);
    wr(`TAD_ADDR_MODE, 32'h0);
    wr(`TAD_ADDR_DET, {8'h00, root_mean_square_tag, auto_peak_tag, linear_average_tag,
                       random_sample_tag, negative_peak_tag, positive_peak_tag});
    start(32'h1);
    smp(16'h1000, 1'b0, 1'b0);
    smp(16'h4000, 1'b0, 1'b0);
    smp(16'h2000, 1'b0, 1'b0);
    @(posedge clk_sys);
    smp_in <= '{valid: 1'b1, value: 16'h3000, point_end: 1'b1, sweep_end: 1'b1};
    @(posedge clk_sys);
    smp_in <= '0;
    @(negedge clk_sys);
    chk({31'h0, busy}, 32'h1, "busy after point end");
    repeat (120) @(posedge clk_sys);
    chk({31'h0, busy}, 32'h0, "busy cleared");
    peek(3'h0, 9'h0);
    chk(rv, 32'h4000, "positive peak");
    peek(3'h1, 9'h0);
    chk(rv, 32'h1000, "negative peak");
    peek(3'h2, 9'h0);
    chk({31'h0, rv[15:0] inside {16'h1000, 16'h2000, 16'h3000, 16'h4000}}, 32'h1, "pick");
    peek(3'h3, 9'h0);
    chkn(rv, 32'h2800, "linear average");
    peek(3'h4, 9'h0);
    chk(rv, 32'h4000, "auto peak shown");
    peek(3'h5, 9'h0);
    chkn(rv, 32'h0780, "mean square");
    rd(`TAD_ADDR_APK);
    chk(rv, 32'h1000_4000, "auto peak pair");
  endtask

  task automatic s_avg();
    wr(`TAD_ADDR_MODE, mp(TM_AVERAGE, TM_MAX_HOLD, TM_MIN_HOLD));
    wr(`TAD_ADDR_DET, 32'h0011_1111);
    wr(`TAD_ADDR_CTRL, 32'h0000_8004);
    start(32'h1);
    for (int k = 0; k < 5; k++) begin
      sweep(cur[k]);
      peek(3'h0, 9'h3);
      chkn(rv, {16'h0, avg[k]}, "average trace");
      peek(3'h1, 9'h0);
      chk(rv, {16'h0, mxh[k]}, "max hold");
      peek(3'h2, 9'h0);
      chk(rv, {16'h0, mnh[k]}, "min hold");
      chk({31'h0, stat_done}, {31'h0, k >= 3}, "cycle done");
      rd(`TAD_ADDR_STAT);
      chk({16'h0, rv[15:0]}, 32'(k + 1), "sweep index");
    end
    wr(`TAD_ADDR_CTRL, 32'h0000_8000);
    sweep(16'h0546);
    peek(3'h0, 9'h0);
    chkn(rv, 32'h01C2, "tenth weighting");
    wr(`TAD_ADDR_CTRL, 32'h0000_8001);
    sweep(16'h004D);
    peek(3'h0, 9'h0);
    chk(rv, 32'h004D, "no averaging");
    wr(`TAD_ADDR_MODE, mp(TM_AVERAGE, TM_MIN_HOLD, TM_MIN_HOLD));
    repeat (2) @(posedge clk_sys);
    peek(3'h1, 9'h0);
    chk(rv, 32'h0, "mode change clears");
  endtask

  task automatic s_single();
    wr(`TAD_ADDR_MODE, mp(TM_AVERAGE, TM_BLANK, TM_BLANK));
    wr(`TAD_ADDR_CTRL, 32'h0000_0002);
    start(32'h1);
    sweep(16'h0064);
    sweep(16'h012C);
    chk({31'h0, stat_done}, 32'h1, "single done");
    // Halted now, so this sweep must leave the trace alone
    sweep(16'h0384);
    peek(3'h0, 9'h0);
    chkn(rv, 32'h00C8, "halted trace");
    start(32'h2);
    sweep(16'h0258);
    peek(3'h0, 9'h0);
    chkn(rv, 32'h0190, "continue single");
    rd(`TAD_ADDR_STAT);
    chk({16'h0, rv[15:0]}, 32'h3, "single count");
  endtask

  // Two values spread over four points; filters start from zero at start
  task automatic s_interp();
    wr(`TAD_ADDR_MODE, mp(TM_CLEAR_WRITE, TM_CLEAR_WRITE, TM_CLEAR_WRITE));
    wr(`TAD_ADDR_DET, {20'h00000, quasi_peak_tag, standard_average_tag, positive_peak_tag});
    wr(`TAD_ADDR_CTRL, 32'h0001_8001);
    start(32'h1);
    smp(16'h0100, 1'b1, 1'b0);
    smp(16'h0300, 1'b1, 1'b1);
    peek(3'h0, 9'h2);
    chk(rv, 32'h0200, "interpolated point");
    peek(3'h0, 9'h3);
    chk(rv, 32'h0300, "measured point");
    peek(3'h1, 9'h3);
    chk(rv, 32'h003F, "standard average");
    peek(3'h2, 9'h3);
    chk(rv, 32'h003F, "quasi peak");
    peek(3'h2, 9'h2);
    chk(rv, 32'h0027, "quasi peak halfway");
  endtask

  initial begin
    repeat (20) @(posedge clk_sys);
    rst <= 1'b0;
    s_reset();
    s_detect();
    s_avg();
    s_single();
    s_interp();
    tally_and_finish();
  end
endmodule
